//--- crp_consts.svh
/*
  Constants of the continuous-run and preset block: clock and unit
  scaling, parameter ranges, reset values, register offsets, bus responses.
  Assumes inclusion by bare name from the design and its package users.
*/
`ifndef CRP_CONSTS_SVH
`define CRP_CONSTS_SVH

// Clock rate and acceleration unit scaling
`define CRP_CLK_HZ         32'h0262_5a00
`define CRP_NS_PER_S       32'h3b9a_ca00
`define CRP_RATE_NUM       (`CRP_NS_PER_S / `CRP_CLK_HZ)
`define CRP_TIME_UNIT_DIV  32'h0000_03e8
`define CRP_TICKS_PER_UNIT (`CRP_CLK_HZ / `CRP_TIME_UNIT_DIV)

// Parameter ranges and reset values
`define CRP_PAR_MIN        20'h0_0001
`define CRP_PAR_MAX        20'hf_4240
`define CRP_PAR_INIT       20'h0_03e8
`define CRP_VS_INIT        20'h0_01f4
`define CRP_PRESET_INIT    24'h00_0000
`define CRP_CTRL_INIT      2'h0

// Register byte offsets
`define CRP_OFS_CTRL       8'h00
`define CRP_OFS_PRESET     8'h04
`define CRP_OFS_VS         8'h08
`define CRP_OFS_SH_ACC     8'h0c
`define CRP_OFS_SH_DEC     8'h10
`define CRP_OFS_TBL_IDX    8'h14
`define CRP_OFS_TBL_SPD    8'h18
`define CRP_OFS_TBL_ACC    8'h1c
`define CRP_OFS_TBL_DEC    8'h20
`define CRP_OFS_CMD_POS    8'h24
`define CRP_OFS_STATUS     8'h28
`define CRP_OFS_CUR_SPD    8'h2c

// Bus responses
`define CRP_RESP_OKAY      2'h0
`define CRP_RESP_SLVERR    2'h2

`endif

//--- crp_host.sv
/*
  Host controller model: drives run, select, preset and alarm lines.
  Assumes the bench calls its tasks; lines change just after I_MCLK rises.
*/
`timescale 1ns/1ps

module crp_host (
  // Clock and status from the drive
  input  wire logic       i_clk,
  input  wire logic       i_ready,
  input  wire logic       i_home_p,
  // Motion lines to the drive
  output logic            o_forward_run,
  output logic            o_reverse_run,
  output logic [5:0]      o_data_select,
  output logic            o_preset_req,
  output logic            o_alarm
);
  // Idle levels from time zero
  initial
  begin
    o_forward_run = 1'h0;
    o_reverse_run = 1'h0;
    o_data_select = 6'h00;
    o_preset_req  = 1'h0;
    o_alarm       = 1'h0;
  end

  // Select settles two cycles before any direction change
  task automatic set_sel(input logic [5:0] s);
    @(posedge i_clk);
    o_data_select <= s;
    repeat (2) @(posedge i_clk);
  endtask

  task automatic drive(input logic f, input logic r);
    @(posedge i_clk);
    o_forward_run <= f;
    o_reverse_run <= r;
  endtask

  // Start only from ready; bounded so a stuck drive cannot hang us
  task automatic start(input logic f, input logic r);
    int i;
    for (i = 0; i < 200 && i_ready !== 1'h1; i++) @(posedge i_clk);
    drive(f, r);
  endtask

  // Obeying host waits for ready and drops on the flag; else holds 8
  task automatic preset(input logic obey);
    int i;
    if (obey)
      for (i = 0; i < 200 && i_ready !== 1'h1; i++) @(posedge i_clk);
    @(posedge i_clk);
    o_preset_req <= 1'h1;
    for (i = 0; i < 8 && !(obey && i_home_p === 1'h1); i++)
      @(posedge i_clk);
    o_preset_req <= 1'h0;
    @(posedge i_clk);
  endtask

  task automatic set_alarm(input logic a);
    @(posedge i_clk);
    o_alarm <= a;
  endtask
endmodule

//--- crp_pkg.sv
/*
  Types of the continuous-run and preset block.
  Assumes crp_consts.svh holds the numbers.
*/
package crp_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DECSTOP} crp_state_t;

  typedef struct packed {
    logic unit_time;
    logic common;
  } crp_ctrl_t;

  typedef struct packed {
    logic [19:0] spd;
    logic [19:0] acc;
    logic [19:0] dec;
  } crp_entry_t;
endpackage

//--- crp_top.sv
/*
  Continuous-run motion control with position preset, registers on
  AXI4-Lite, a linear speed ramp and a step-rate generator.
  Assumes run, select, preset and alarm inputs synchronous to I_MCLK.
*/
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`include "crp_consts.svh"

module crp_top
  import crp_pkg::*;
(
  // Clock and reset
  input  wire logic        I_MCLK,
  input  wire logic        I_RST,
  // Motion inputs
  input  wire logic        I_FORWARD_RUN,
  input  wire logic        I_REVERSE_RUN,
  input  wire logic [5:0]  I_DATA_SELECT,
  input  wire logic        I_PRESET_REQ,
  input  wire logic        I_ALARM,
  // Motion outputs
  output logic             O_READY,
  output logic             O_MOVE,
  output logic             O_HOME_P,
  output logic             O_STEP,
  output logic             O_DIR,
  // AXI4-Lite write
  input  wire logic [7:0]  I_AWADDR,
  input  wire logic        I_AWVALID,
  output logic             O_AWREADY,
  input  wire logic [31:0] I_WDATA,
  input  wire logic [3:0]  I_WSTRB,
  input  wire logic        I_WVALID,
  output logic             O_WREADY,
  output logic [1:0]       O_BRESP,
  output logic             O_BVALID,
  input  wire logic        I_BREADY,
  // AXI4-Lite read
  input  wire logic [7:0]  I_ARADDR,
  input  wire logic        I_ARVALID,
  output logic             O_ARREADY,
  output logic [31:0]      O_RDATA,
  output logic [1:0]       O_RRESP,
  output logic             O_RVALID,
  input  wire logic        I_RREADY
);

  crp_state_t   state;
  crp_state_t   next_state;
  crp_ctrl_t    cfg;
  crp_entry_t   tbl [64];
  crp_entry_t   sel_e;
  logic [23:0]  preset_pos;
  logic [23:0]  cmd_pos;
  logic [19:0]  vs;
  logic [19:0]  sh_acc;
  logic [19:0]  sh_dec;
  logic [5:0]   tidx;
  logic [19:0]  cur_spd;
  logic [19:0]  acc_v;
  logic [19:0]  dec_v;
  logic [19:0]  rval;
  logic [19:0]  diff;
  logic [36:0]  num;
  logic [36:0]  den;
  logic [36:0]  ramp_acc;
  logic [36:0]  sum;
  logic [25:0]  phase;
  logic [26:0]  psum;
  logic         up;
  logic         dn;
  logic         bump;
  logic         one;
  logic         both;
  logic         same;
  logic         opp;
  logic         at_stop;
  logic         preset_d;
  logic         preset_take;
  logic         aw_got;
  logic         w_got;
  logic [7:0]   aw_addr;
  logic [31:0]  w_data;
  logic [3:0]   w_strb;
  logic         wr_go;
  logic [31:0]  wval;

  // Register read view, shared by reads and byte merging
  function automatic logic [31:0] reg_rd(input logic [7:0] a);
    case (a)
      `CRP_OFS_CTRL:    reg_rd = {30'h0, cfg};
      `CRP_OFS_PRESET:  reg_rd = {{8{preset_pos[23]}}, preset_pos};
      `CRP_OFS_VS:      reg_rd = {12'h0, vs};
      `CRP_OFS_SH_ACC:  reg_rd = {12'h0, sh_acc};
      `CRP_OFS_SH_DEC:  reg_rd = {12'h0, sh_dec};
      `CRP_OFS_TBL_IDX: reg_rd = {26'h0, tidx};
      `CRP_OFS_TBL_SPD: reg_rd = {12'h0, tbl[tidx].spd};
      `CRP_OFS_TBL_ACC: reg_rd = {12'h0, tbl[tidx].acc};
      `CRP_OFS_TBL_DEC: reg_rd = {12'h0, tbl[tidx].dec};
      `CRP_OFS_CMD_POS: reg_rd = {{8{cmd_pos[23]}}, cmd_pos};
      `CRP_OFS_STATUS:
        reg_rd = {28'h0, O_DIR, O_HOME_P, O_MOVE, O_READY};
      `CRP_OFS_CUR_SPD: reg_rd = {12'h0, cur_spd};
      default:          reg_rd = 32'h0;
    endcase
  endfunction

  function automatic logic hit(input logic [7:0] a);
    hit = (a[1:0] == 2'h0) && (a <= `CRP_OFS_CUR_SPD);
  endfunction

  // Out-of-range values are clamped rather than refused
  function automatic logic [19:0] clampv(input logic [31:0] v);
    if (v < 32'(`CRP_PAR_MIN))
      clampv = `CRP_PAR_MIN;
    else if (v > 32'(`CRP_PAR_MAX))
      clampv = `CRP_PAR_MAX;
    else
      clampv = v[19:0];
  endfunction

  // Byte-lane merge of write data over the current value
  always_comb
  begin
    wval = reg_rd(aw_addr);
    for (int b = 0; b < 4; b++)
      if (w_strb[b])
        wval[8*b +: 8] = w_data[8*b +: 8];
  end

  assign wr_go = aw_got && w_got && !O_BVALID;

  // Write address and data are taken in either order
  always_ff @(posedge I_MCLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      aw_got    <= 1'b0;
      w_got     <= 1'b0;
      aw_addr   <= 8'h00;
      w_data    <= 32'h0;
      w_strb    <= 4'h0;
      O_AWREADY <= 1'b1;
      O_WREADY  <= 1'b1;
      O_BVALID  <= 1'b0;
      O_BRESP   <= `CRP_RESP_OKAY;
    end
    else
    begin
      if (I_AWVALID && O_AWREADY)
      begin
        aw_got    <= 1'b1;
        aw_addr   <= I_AWADDR;
        O_AWREADY <= 1'b0;
      end
      if (I_WVALID && O_WREADY)
      begin
        w_got    <= 1'b1;
        w_data   <= I_WDATA;
        w_strb   <= I_WSTRB;
        O_WREADY <= 1'b0;
      end
      if (wr_go)
      begin
        O_BVALID <= 1'b1;
        O_BRESP  <= hit(aw_addr) ? `CRP_RESP_OKAY : `CRP_RESP_SLVERR;
      end
      if (O_BVALID && I_BREADY)
      begin
        O_BVALID  <= 1'b0;
        aw_got    <= 1'b0;
        w_got     <= 1'b0;
        O_AWREADY <= 1'b1;
        O_WREADY  <= 1'b1;
      end
    end
  end

  // Read channel: one outstanding read, answered the next cycle
  always_ff @(posedge I_MCLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      O_ARREADY <= 1'b1;
      O_RVALID  <= 1'b0;
      O_RDATA   <= 32'h0;
      O_RRESP   <= `CRP_RESP_OKAY;
    end
    else if (I_ARVALID && O_ARREADY)
    begin
      O_ARREADY <= 1'b0;
      O_RVALID  <= 1'b1;
      O_RDATA   <= reg_rd(I_ARADDR);
      O_RRESP   <= hit(I_ARADDR) ? `CRP_RESP_OKAY : `CRP_RESP_SLVERR;
    end
    else if (O_RVALID && I_RREADY)
    begin
      O_RVALID  <= 1'b0;
      O_ARREADY <= 1'b1;
    end
  end

  // Configuration registers; reset holds a full table of defaults
  always_ff @(posedge I_MCLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      cfg        <= `CRP_CTRL_INIT;
      preset_pos <= `CRP_PRESET_INIT;
      vs         <= `CRP_VS_INIT;
      sh_acc     <= `CRP_PAR_INIT;
      sh_dec     <= `CRP_PAR_INIT;
      tidx       <= 6'h00;
      for (int i = 0; i < 64; i++)
        tbl[i] <= '{`CRP_PAR_INIT, `CRP_PAR_INIT, `CRP_PAR_INIT};
    end
    else if (wr_go)
    begin
      case (aw_addr)
        `CRP_OFS_CTRL:    cfg        <= wval[1:0];
        `CRP_OFS_PRESET:  preset_pos <= wval[23:0];
        `CRP_OFS_VS:      vs         <= clampv(wval);
        `CRP_OFS_SH_ACC:  sh_acc     <= clampv(wval);
        `CRP_OFS_SH_DEC:  sh_dec     <= clampv(wval);
        `CRP_OFS_TBL_IDX: tidx       <= wval[5:0];
        `CRP_OFS_TBL_SPD: tbl[tidx].spd <= clampv(wval);
        `CRP_OFS_TBL_ACC: tbl[tidx].acc <= clampv(wval);
        `CRP_OFS_TBL_DEC: tbl[tidx].dec <= clampv(wval);
        default:          ;
      endcase
    end
  end

  // Direction input decode and entry selection
  always_comb
  begin
    sel_e = tbl[I_DATA_SELECT];
    one   = I_FORWARD_RUN ^ I_REVERSE_RUN;
    both  = I_FORWARD_RUN & I_REVERSE_RUN;
    same  = one & (O_DIR ? I_REVERSE_RUN : I_FORWARD_RUN);
    opp   = one & !same;
    acc_v = cfg.common ? sh_acc : sel_e.acc;
    dec_v = cfg.common ? sh_dec : sel_e.dec;
  end

  // Ramp engine: fractional accumulator, one Hz per overflow.
  // Avoids a divider; caps the slope at 1 Hz per cycle.
  always_comb
  begin
    up      = (state == ST_RUN) && (cur_spd < sel_e.spd);
    dn      = ((state == ST_RUN) && (cur_spd > sel_e.spd))
              || (state == ST_DECSTOP);
    rval    = up ? acc_v : dec_v;
    diff    = (sel_e.spd > vs) ? (sel_e.spd - vs) : 20'h1;
    num     = cfg.unit_time ? {17'h0, diff}
                            : 37'(`CRP_RATE_NUM);
    den     = cfg.unit_time ? 37'(rval) * 37'(`CRP_TICKS_PER_UNIT)
                            : 37'(rval);
    sum     = ramp_acc + num;
    bump    = (up || dn) && (sum >= den);
    at_stop = (state == ST_DECSTOP) && (cur_spd <= vs);
  end

  // Next motion state
  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (O_READY && one)
          next_state = ST_RUN;
      ST_RUN:
        if (both || !same)
          next_state = ST_DECSTOP;
      ST_DECSTOP:
        if (same)
          next_state = ST_RUN;
        else if (at_stop)
          next_state = opp ? ST_RUN : ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  // State, speed, direction and status flags
  always_ff @(posedge I_MCLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      state    <= ST_IDLE;
      cur_spd  <= 20'h0;
      ramp_acc <= 37'h0;
      O_DIR    <= 1'b0;
      O_MOVE   <= 1'b0;
      O_READY  <= 1'b0;
    end
    else
    begin
      state  <= next_state;
      O_MOVE <= (next_state != ST_IDLE);
      O_READY <= (next_state == ST_IDLE) && !I_ALARM
                 && !I_FORWARD_RUN && !I_REVERSE_RUN;
      if (!(up || dn) || (state == ST_IDLE) || at_stop)
        ramp_acc <= 37'h0;
      else
        ramp_acc <= bump ? (sum - den) : sum;
      if ((state == ST_IDLE) && (next_state == ST_RUN))
      begin
        cur_spd <= vs;
        O_DIR   <= I_REVERSE_RUN;
      end
      // Opposite input at the stop point restarts at the start speed, with a flip
      else if (at_stop && opp)
      begin
        cur_spd <= vs;
        O_DIR   <= !O_DIR;
      end
      else if (at_stop && !same)
        cur_spd <= 20'h0;
      else if (bump)
        cur_spd <= up ? (cur_spd + 20'h1) : (cur_spd - 20'h1);
    end
  end

  // Step-rate generator: phase accumulator at the current speed
  always_comb
  begin
    psum = {1'b0, phase} + {7'h0, cur_spd};
  end

  always_ff @(posedge I_MCLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      phase  <= 26'h0;
      O_STEP <= 1'b0;
    end
    else if (psum >= 27'(`CRP_CLK_HZ))
    begin
      phase  <= 26'(psum - 27'(`CRP_CLK_HZ));
      O_STEP <= 1'b1;
    end
    else
    begin
      phase  <= psum[25:0];
      O_STEP <= 1'b0;
    end
  end

  // Preset taken on a rising request, only at rest and alarm-free
  assign preset_take = I_PRESET_REQ && !preset_d
                       && (state == ST_IDLE) && !I_ALARM;

  always_ff @(posedge I_MCLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      preset_d <= 1'b0;
      cmd_pos  <= 24'h0;
      O_HOME_P <= 1'b0;
    end
    else
    begin
      preset_d <= I_PRESET_REQ;
      if (preset_take)
      begin
        cmd_pos  <= preset_pos;
        O_HOME_P <= 1'b1;
      end
      else
      begin
        if (O_STEP)
          cmd_pos <= O_DIR ? (cmd_pos - 24'h1) : (cmd_pos + 24'h1);
        if (next_state != ST_IDLE)
          O_HOME_P <= 1'b0;
      end
    end
  end

  // Checks on the motion and preset behaviour
  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (I_RST);

  sequence preset_req_s;
    I_PRESET_REQ && !preset_d && (state == ST_IDLE) && !I_ALARM;
  endsequence

  sequence stop_here_s;
    (state == ST_DECSTOP) && (cur_spd <= vs) && !same;
  endsequence

  preset_load_a: assert property (
    preset_req_s |=> (cmd_pos == $past(preset_pos)) && O_HOME_P)
    else $error("preset value not loaded");

  preset_block_a: assert property (
    $rose(O_HOME_P) |-> $past(state == ST_IDLE) && $past(!I_ALARM))
    else $error("preset taken while moving or in alarm");

  home_flag_a: assert property (
    O_HOME_P && (state == ST_IDLE) && (next_state == ST_IDLE)
    |=> O_HOME_P)
    else $error("home flag dropped at rest");

  run_hold_a: assert property (
    (state == ST_RUN) && same |=> (state == ST_RUN) && O_MOVE)
    else $error("run stopped while input held");

  both_stop_a: assert property (
    (state == ST_RUN) && both |=> (state == ST_DECSTOP))
    else $error("both inputs did not decelerate");

  reaccel_a: assert property (
    (state == ST_DECSTOP) && same |=> (state == ST_RUN) && O_MOVE)
    else $error("same input did not re-accelerate");

  move_clear_a: assert property (
    stop_here_s ##0 !opp |=> !O_MOVE && (cur_spd == 20'h0))
    else $error("moving not cleared at standstill");

  reverse_a: assert property (
    stop_here_s ##0 opp |=> (O_DIR != $past(O_DIR)) && (cur_spd == vs))
    else $error("reversal did not stop and turn");

  ready_drop_a: assert property (
    O_READY && one |=> (!O_READY && O_MOVE) [*2])
    else $error("ready not dropped at start");

endmodule

//--- crp_top_tb_top.sv
/*
  Self-checking bench for crp_top: AXI4-Lite master tasks and scenarios.
  Assumes crp_host drives the motion lines and the constants header.
*/
`timescale 1ns/1ps
`include "crp_consts.svh"

module crp_top_tb_top;
  // Clock, reset and bus master state
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'h0;
  logic        wvalid = 1'h0;
  logic        bready = 1'h0;
  logic        arvalid = 1'h0;
  logic        rready = 1'h0;
  logic [3:0]  wstrb = 4'hf;
  wire         forward_run_input, reverse_run_input, prq, alm;
  wire  [5:0]  sel;
  logic        ready, move, home_p, step, dir;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  wire  [3:0]  st = {dir, home_p, move, ready};
  int          bad_count = 0;
  int          n_tests = 0;
  int          n_step = 0;

  always #12.5 clk = ~clk;

  // Step pulses seen, to match against the command position
  always @(posedge clk)
    if (step)
      n_step <= n_step + 1;

  crp_host host (.i_clk(clk), .i_ready(ready), .i_home_p(home_p),
    .o_forward_run(forward_run_input), .o_reverse_run(reverse_run_input), .o_data_select(sel),
    .o_preset_req(prq), .o_alarm(alm));

  crp_top uut (.I_MCLK(clk), .I_RST(rst), .I_FORWARD_RUN(forward_run_input),
    .I_REVERSE_RUN(reverse_run_input), .I_DATA_SELECT(sel), .I_PRESET_REQ(prq),
    .I_ALARM(alm), .O_READY(ready), .O_MOVE(move), .O_HOME_P(home_p),
    .O_STEP(step), .O_DIR(dir), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
    .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(wstrb),
    .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp),
    .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr),
    .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata),
    .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready));

  task automatic finish_test();
    if (bad_count == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Address and data offered together, each dropped when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] er = 2'h0,
                        input logic [3:0] s = 4'hf);
    logic done;
    done = 1'h0;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    while (!done)
    begin
      @(posedge clk);
      awvalid <= awvalid && !awready;
      wvalid  <= wvalid && !wready;
      bready  <= !bvalid;
      if (bvalid)
      begin
        done = 1'h1;
        chk("write resp", {30'h0, er}, {30'h0, bresp});
      end
    end
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    logic done;
    done = 1'h0;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    while (!done)
    begin
      @(posedge clk);
      arvalid <= arvalid && !arready;
      rready  <= !rvalid;
      if (rvalid)
      begin
        d = rdata;
        r = rresp;
        done = 1'h1;
      end
    end
  endtask

  task automatic rd(input string nm, input logic [7:0] a,
                    input logic [31:0] e, input logic [1:0] er = 2'h0);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    chk(nm, e, d);
    chk({nm, " resp"}, {30'h0, er}, {30'h0, r});
  endtask

  // Status bit: 0 ready, 1 move, 2 home, 3 dir; bounded wait
  task automatic wt(input int b, input logic v, input string nm);
    int i;
    for (i = 0; i < 200 && st[b] !== v; i++) @(posedge clk);
    chk(nm, {31'h0, v}, {31'h0, st[b]});
  endtask

  // Poll bound is tight so a too-slow ramp shows as a mismatch
  task automatic wait_spd(input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    int          i;
    for (i = 0; i < 40; i++)
    begin
      axi_rd(`CRP_OFS_CUR_SPD, d, r);
      if (d === e) break;
    end
    chk("speed", e, d);
  endtask

  task automatic set_ent(input logic [5:0] n, input logic [31:0] s);
    axi_wr(`CRP_OFS_TBL_IDX, {26'h0, n});
    axi_wr(`CRP_OFS_TBL_SPD, s);
    axi_wr(`CRP_OFS_TBL_ACC, 32'h1);
    axi_wr(`CRP_OFS_TBL_DEC, 32'h1);
  endtask

  task automatic t_regs();
    rd("preset", `CRP_OFS_PRESET, 32'h0);
    rd("entry speed", `CRP_OFS_TBL_SPD, 32'h3e8);
    rd("entry acc", `CRP_OFS_TBL_ACC, 32'h3e8);
    rd("entry dec", `CRP_OFS_TBL_DEC, 32'h3e8);
    rd("unmapped", 8'h30, 32'h0, 2'h2);
    axi_wr(8'h34, 32'h1, 2'h2);
    axi_wr(`CRP_OFS_PRESET, 32'h0080_0000);
    rd("preset min", `CRP_OFS_PRESET, 32'hff80_0000);
    axi_wr(`CRP_OFS_PRESET, 32'h1234_56ab, 2'h0, 4'h1);
    rd("preset byte", `CRP_OFS_PRESET, 32'hff80_00ab);
  endtask

  task automatic t_sep();
    axi_wr(`CRP_OFS_VS, 32'h3de);
    set_ent(6'h00, 32'h3e8);
    set_ent(6'h01, 32'h3f2);
    set_ent(6'h3f, 32'h3ed);
    host.set_sel(6'h00);
    host.start(1'h1, 1'h0);
    wt(1, 1'h1, "move");
    wt(0, 1'h0, "ready");
    wait_spd(32'h3e8);
    host.set_sel(6'h01);
    wait_spd(32'h3f2);
    host.set_sel(6'h3f);
    wait_spd(32'h3ed);
    host.drive(1'h0, 1'h0);
    wt(1, 1'h0, "move stop");
    wt(0, 1'h1, "ready back");
  endtask

  task automatic t_rev();
    host.set_sel(6'h00);
    host.start(1'h1, 1'h0);
    wait_spd(32'h3e8);
    host.drive(1'h0, 1'h0);
    repeat (3) @(posedge clk);
    host.drive(1'h1, 1'h0);
    wait_spd(32'h3e8);
    wt(1, 1'h1, "move kept");
    host.drive(1'h0, 1'h1);
    wt(3, 1'h1, "dir");
    wt(1, 1'h1, "move on");
    wait_spd(32'h3e8);
    host.drive(1'h1, 1'h1);
    wt(1, 1'h0, "move both");
    repeat (3) @(posedge clk);
    wt(0, 1'h0, "ready held");
    host.drive(1'h0, 1'h0);
    wt(0, 1'h1, "ready free");
  endtask

  // Entry 2 keeps slow ramps, so only shared ramps finish in time
  task automatic t_common();
    axi_wr(`CRP_OFS_CTRL, 32'h1);
    axi_wr(`CRP_OFS_SH_ACC, 32'h1);
    axi_wr(`CRP_OFS_SH_DEC, 32'h1);
    host.set_sel(6'h02);
    host.start(1'h1, 1'h0);
    wait_spd(32'h3e8);
    host.drive(1'h0, 1'h0);
    wt(1, 1'h0, "common stop");
  endtask

  // Start speed at full rate gives a step every 40 cycles; a preset
  // raised mid-run must leave the step-counted position alone
  task automatic t_step();
    logic [31:0] p0;
    logic [31:0] p1;
    logic [1:0]  r;
    int          s0;
    axi_wr(`CRP_OFS_VS, 32'h000f_4240);
    set_ent(6'h04, 32'h000f_4240);
    host.set_sel(6'h04);
    axi_rd(`CRP_OFS_CMD_POS, p0, r);
    s0 = n_step;
    host.start(1'h1, 1'h0);
    wt(1, 1'h1, "move step");
    host.preset(1'h0);
    wt(2, 1'h0, "home moving");
    repeat (400) @(posedge clk);
    host.drive(1'h0, 1'h0);
    wt(1, 1'h0, "move end");
    axi_rd(`CRP_OFS_CMD_POS, p1, r);
    chk("steps seen", 32'h1, {31'h0, (n_step - s0) > 4});
    chk("step count", p0 + (n_step - s0), p1);
  endtask

  task automatic t_preset();
    logic [31:0] p0;
    logic [1:0]  r;
    axi_rd(`CRP_OFS_CMD_POS, p0, r);
    axi_wr(`CRP_OFS_PRESET, 32'h00ff_fffe);
    host.set_alarm(1'h1);
    host.preset(1'h0);
    wt(2, 1'h0, "home alarm");
    rd("pos alarm", `CRP_OFS_CMD_POS, p0);
    host.set_alarm(1'h0);
    host.preset(1'h1);
    wt(2, 1'h1, "home done");
    rd("pos preset", `CRP_OFS_CMD_POS, 32'hffff_fffe);
  endtask

  // Main sequence after 12 cycles of reset
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    t_regs();
    t_sep();
    t_rev();
    t_common();
    t_step();
    t_preset();
    finish_test();
  end

  // Watchdog well above the expected run of under a thousand cycles
  initial
  begin
    #(25 * 40000);
    bad_count++;
    finish_test();
  end
endmodule
